// file: rtl/stp_consts.vh
// constants of the sixteen-bit timer with pwm and capture
// Functional notes
// - Setting the run bit starts counting on the selected count clock.
// - Interval mode: counter equal to period register clears to zero, raises match.
// - Period value N gives N plus one count clocks between matches.
// - Trigger enable bit in control register 2 gates the conversion trigger.
// - Counter equal to capture/compare zero emits trigger; period match still clears.
// - Trigger only when capture/compare zero is strictly below the period value.
// - Triggers recur each period, M count clocks after counter passes zero.
// - Capture mode: rising edge of chosen source copies counter into capture/compare zero.
// - Unit 0 captures on comparator 2 or external input; unit 1 on comparator 1.
// - Capture source select bit exists only in unit 0 control register 2.
// - In capture mode the counter still clears on the period match.
// - Pwm mode: pin 0 inverts at compare 0 count, completes cycle at compare 1.
// - Pwm period is compare 1 plus one; duty is (cmp1-cmp0)/(cmp1+1).
// - New pwm values load at first match after compare 1 write, deferred near match.
// - Rewrites before a pending update lands take the latest values.
// - Compare 0 equal to compare 1 holds pin 0 at its default level.
`ifndef STP_CONSTS_VH
`define STP_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define STP_OFS_CTRL0   8'h00
`define STP_OFS_CTRL1   8'h04
`define STP_OFS_CTRL2   8'h08
`define STP_OFS_CR0     8'h0c
`define STP_OFS_CR1     8'h10
`define STP_OFS_CR2     8'h14
`define STP_OFS_CR3     8'h18
`define STP_OFS_CCR0    8'h1c
`define STP_OFS_COUNT   8'h20
`define STP_OFS_STATUS  8'h24

// ----------------------------------------
// field positions
// ----------------------------------------
`define STP_RUN_BIT     7
`define STP_PER_SEL_BIT 2
`define STP_ADC_EN_BIT  1
`define STP_SRC_SEL_BIT 0
`define STP_ST_MATCH    0
`define STP_ST_TRIG     1
`define STP_ST_CAPT     2

// ----------------------------------------
// operating modes in control register 1
// ----------------------------------------
`define STP_MODE_INTERVAL 2'h0
`define STP_MODE_ADC      2'h1
`define STP_MODE_CAPTURE  2'h2
`define STP_MODE_PWM      2'h3

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define STP_RST_CTRL    8'h00
`define STP_RST_CMP     16'hffff
`define STP_RST_ZERO16  16'h0000
`define STP_DEFER_TICKS 17'h00002

`endif

// file: rtl/stp_edge_sync.v
// two-stage synchroniser with rising edge detect, one lane per input
`timescale 1ns/100ps

module stp_edge_sync #(
	parameter WIDTH = 3
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] rise_o
);

	// ----------------------------------------
	// per lane synchroniser
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_lane
			reg meta_r;
			reg sync_r;
			reg last_r;
			// first stage feeds only the second stage
			always @(posedge clk_i) begin
				if (rst_i) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
					last_r <= 1'b0;
				end else begin
					meta_r <= async_i[g];
					sync_r <= meta_r;
					last_r <= sync_r;
				end
			end
			assign rise_o[g] = sync_r & ~last_r; // one-cycle pulse
		end
	endgenerate

endmodule // stp_edge_sync

// file: rtl/stp_timer.v
// sixteen-bit timer channel: interval, conversion trigger, capture, single pwm
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "stp_consts.vh"

module stp_timer #(
	parameter UNIT = 0
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        comparator1_event_i,
	input  wire        comparator2_event_i,
	input  wire        ext_irq_input_i,
	output reg         match_irq_o,
	output reg         adc_trig_o,
	output reg         pwm_out_pin0_o
);

	// ----------------------------------------
	// byte lane merge helpers
	// ----------------------------------------
	function [15:0] bw16;
		input [15:0] old;
		input [15:0] d;
		input [1:0]  s;
		begin
			bw16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	function [7:0] bw8;
		input [7:0] old;
		input [7:0] d;
		input       s;
		begin
			bw8 = s ? d : old;
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg  [7:0]  timer_ctrl_reg0_r;
	reg  [7:0]  timer_ctrl_reg1_r;
	reg  [7:0]  timer_ctrl_reg2_r;
	reg  [15:0] pwm_invert_compare_r;
	reg  [15:0] pwm_cycle_compare_r;
	reg  [15:0] cr2_r;
	reg  [15:0] cr3_r;
	reg  [15:0] capture_compare_zero_r;
	reg  [15:0] timer_counter_value_r;
	reg  [15:0] act_cr0_r;
	reg  [15:0] act_cr1_r;
	reg  [2:0]  status_r;
	reg         pend_r;
	reg         late_r;
	reg  [7:0]  presc_r;
	reg  [31:0] rd_nxt;

	wire [2:0]  edge_rise;
	wire [7:0]  ofs;
	wire        acc;
	wire        wr;
	wire        count_run_bit;
	wire [1:0]  mode;
	wire        adc_trigger_enable;
	wire        capture_source_select;
	wire [15:0] period;
	wire [7:0]  presc_mask;
	wire        tick;
	wire        hit_per;
	wire        hit_trig;
	wire        cap_src;
	wire        cap_hit;
	wire        wr_cr1;
	wire        pwm_mode;

	// ----------------------------------------
	// capture sources, synchronised from the pins
	// ----------------------------------------
	stp_edge_sync #(
		.WIDTH (3)
	) u_edge (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({ext_irq_input_i, comparator2_event_i, comparator1_event_i}),
		.rise_o  (edge_rise)
	);

	// ----------------------------------------
	// decode and control fields
	// ----------------------------------------
	assign ofs                   = {wb_adr_i[7:2], 2'b00};
	assign acc                   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr                    = acc & wb_we_i;
	assign count_run_bit         = timer_ctrl_reg0_r[`STP_RUN_BIT];
	assign mode                  = timer_ctrl_reg1_r[1:0];
	assign pwm_mode              = (mode == `STP_MODE_PWM);
	assign adc_trigger_enable    = timer_ctrl_reg2_r[`STP_ADC_EN_BIT];
	// unit 1 keeps this bit tied low in its register
	assign capture_source_select = timer_ctrl_reg2_r[`STP_SRC_SEL_BIT];
	assign wr_cr1                = wr & (ofs == `STP_OFS_CR1) & (|wb_sel_i[1:0]);

	// period register: pwm uses the live shadow, others the chosen compare
	assign period = pwm_mode ? act_cr1_r :
		(timer_ctrl_reg1_r[`STP_PER_SEL_BIT] ? cr3_r : pwm_cycle_compare_r);

	// ----------------------------------------
	// count clock prescaler, divide by two to the select
	// ----------------------------------------
	assign presc_mask = ~(8'hff << timer_ctrl_reg0_r[2:0]);
	assign tick       = count_run_bit & ((presc_r & presc_mask) == presc_mask);

	// prescaler restarts on stop so the first count lands one full clock in
	always @(posedge clk_i) begin
		if (rst_i || !count_run_bit) begin
			presc_r <= 8'h00;
		end else begin
			presc_r <= presc_r + 8'h01;
		end
	end

	// ----------------------------------------
	// counter and period match
	// ----------------------------------------
	assign hit_per = tick & (timer_counter_value_r == period);

	// zero period is forbidden to software, so hardware does not guard it
	always @(posedge clk_i) begin
		if (rst_i || !count_run_bit) begin
			timer_counter_value_r <= `STP_RST_ZERO16;
		end else if (hit_per) begin
			timer_counter_value_r <= `STP_RST_ZERO16;
		end else if (tick) begin
			timer_counter_value_r <= timer_counter_value_r + 16'h0001;
		end
	end

	// ----------------------------------------
	// conversion trigger
	// ----------------------------------------
	// a value at or above the period is never met before the clear
	assign hit_trig = tick & (mode == `STP_MODE_ADC) & adc_trigger_enable
		& (timer_counter_value_r == capture_compare_zero_r)
		& (capture_compare_zero_r < period);

	// ----------------------------------------
	// capture source selection
	// ----------------------------------------
	generate
		if (UNIT == 0) begin : g_src0
			assign cap_src = capture_source_select ? edge_rise[2] : edge_rise[1];
		end else begin : g_src1
			assign cap_src = edge_rise[0];
		end
	endgenerate

	assign cap_hit = count_run_bit & (mode == `STP_MODE_CAPTURE) & cap_src;

	// ----------------------------------------
	// event pulses, straight from flops
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			match_irq_o <= 1'b0;
			adc_trig_o  <= 1'b0;
		end else begin
			match_irq_o <= hit_per;
			adc_trig_o  <= hit_trig;
		end
	end

	// ----------------------------------------
	// pwm output on pin 0
	// ----------------------------------------
	// the cycle match is checked first so equal compares keep the pin low
	always @(posedge clk_i) begin
		if (rst_i || !count_run_bit || !pwm_mode) begin
			pwm_out_pin0_o <= 1'b0;
		end else if (tick) begin
			if (timer_counter_value_r == act_cr1_r) begin
				pwm_out_pin0_o <= 1'b0;
			end else if (timer_counter_value_r == act_cr0_r) begin
				pwm_out_pin0_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// pwm shadow update
	// ----------------------------------------
	// loads read the compare registers at the match, so late rewrites win
	always @(posedge clk_i) begin
		if (rst_i) begin
			act_cr0_r <= `STP_RST_CMP;
			act_cr1_r <= `STP_RST_CMP;
			pend_r    <= 1'b0;
			late_r    <= 1'b0;
		end else if (!count_run_bit || !pwm_mode) begin
			act_cr0_r <= pwm_invert_compare_r;
			act_cr1_r <= pwm_cycle_compare_r;
			pend_r    <= 1'b0;
			late_r    <= 1'b0;
		end else if (wr_cr1) begin
			pend_r <= 1'b1;
			late_r <= hit_per |
				(({1'b0, timer_counter_value_r} + `STP_DEFER_TICKS) >= {1'b0, act_cr1_r});
		end else if (hit_per && pend_r) begin
			if (late_r) begin
				late_r <= 1'b0;
			end else begin
				act_cr0_r <= pwm_invert_compare_r;
				act_cr1_r <= pwm_cycle_compare_r;
				pend_r    <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// register writes, capture and sticky status
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			timer_ctrl_reg0_r      <= `STP_RST_CTRL;
			timer_ctrl_reg1_r      <= `STP_RST_CTRL;
			timer_ctrl_reg2_r      <= `STP_RST_CTRL;
			pwm_invert_compare_r   <= `STP_RST_CMP;
			pwm_cycle_compare_r    <= `STP_RST_CMP;
			cr2_r                  <= `STP_RST_CMP;
			cr3_r                  <= `STP_RST_CMP;
			capture_compare_zero_r <= `STP_RST_ZERO16;
			status_r               <= 3'h0;
		end else begin
			if (wr) begin
				case (ofs)
					`STP_OFS_CTRL0: timer_ctrl_reg0_r <= bw8(timer_ctrl_reg0_r, wb_dat_i[7:0], wb_sel_i[0]);
					`STP_OFS_CTRL1: timer_ctrl_reg1_r <= bw8(timer_ctrl_reg1_r, wb_dat_i[7:0], wb_sel_i[0]);
					`STP_OFS_CTRL2: begin
						if (wb_sel_i[0]) begin
							timer_ctrl_reg2_r[`STP_ADC_EN_BIT]  <= wb_dat_i[`STP_ADC_EN_BIT];
							timer_ctrl_reg2_r[`STP_SRC_SEL_BIT] <=
								(UNIT == 0) ? wb_dat_i[`STP_SRC_SEL_BIT] : 1'b0;
						end
					end
					`STP_OFS_CR0: pwm_invert_compare_r <= bw16(pwm_invert_compare_r, wb_dat_i[15:0], wb_sel_i[1:0]);
					`STP_OFS_CR1: pwm_cycle_compare_r <= bw16(pwm_cycle_compare_r, wb_dat_i[15:0], wb_sel_i[1:0]);
					`STP_OFS_CR2: cr2_r <= bw16(cr2_r, wb_dat_i[15:0], wb_sel_i[1:0]);
					`STP_OFS_CR3: cr3_r <= bw16(cr3_r, wb_dat_i[15:0], wb_sel_i[1:0]);
					`STP_OFS_CCR0: begin
						capture_compare_zero_r <= bw16(capture_compare_zero_r, wb_dat_i[15:0], wb_sel_i[1:0]);
					end
					`STP_OFS_STATUS: begin
						if (wb_sel_i[0]) begin
							status_r <= status_r & ~wb_dat_i[2:0]; // write one to clear
						end
					end
					default: begin
					end
				endcase
			end
			// hardware capture beats a software write in the same cycle
			if (cap_hit) begin
				capture_compare_zero_r <= timer_counter_value_r;
			end
			// set wins over clear for each sticky flag
			if (hit_per) begin
				status_r[`STP_ST_MATCH] <= 1'b1;
			end
			if (hit_trig) begin
				status_r[`STP_ST_TRIG] <= 1'b1;
			end
			if (cap_hit) begin
				status_r[`STP_ST_CAPT] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// read mux, unmapped offsets read zero
	// ----------------------------------------
	always @* begin
		rd_nxt = 32'h0000_0000;
		case (ofs)
			`STP_OFS_CTRL0:  rd_nxt[7:0]  = timer_ctrl_reg0_r;
			`STP_OFS_CTRL1:  rd_nxt[7:0]  = timer_ctrl_reg1_r;
			`STP_OFS_CTRL2:  rd_nxt[7:0]  = timer_ctrl_reg2_r;
			`STP_OFS_CR0:    rd_nxt[15:0] = pwm_invert_compare_r;
			`STP_OFS_CR1:    rd_nxt[15:0] = pwm_cycle_compare_r;
			`STP_OFS_CR2:    rd_nxt[15:0] = cr2_r;
			`STP_OFS_CR3:    rd_nxt[15:0] = cr3_r;
			`STP_OFS_CCR0:   rd_nxt[15:0] = capture_compare_zero_r;
			`STP_OFS_COUNT:  rd_nxt[15:0] = timer_counter_value_r;
			`STP_OFS_STATUS: rd_nxt[4:0]  = {pend_r, pwm_out_pin0_o, status_r};
			default:         rd_nxt       = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// wishbone answer, one wait state
	// ----------------------------------------
	// ack drops the cycle after it rises, so a held strobe is not taken twice
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			if (acc && !wb_we_i) begin
				wb_dat_o <= rd_nxt;
			end
		end
	end

endmodule // stp_timer

// file: verification/stp_tb.sv
// self-checking bench for the timer channel
`timescale 1ns/100ps
`include "stp_consts.vh"

module testbench;
	localparam int LIM = 3000;
	logic        clk_i, rst_i, cyc, we, ack;
	logic [7:0]  adr;
	logic [31:0] dat, q, rdat, q1, rdat1;
	logic [2:0]  pins, ev;
	int          seed, error_cnt, n_tests, c, n, m, a, b, k, e;

	stp_timer #(.UNIT(0)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.comparator1_event_i(pins[0]), .comparator2_event_i(pins[1]), .ext_irq_input_i(pins[2]),
		.match_irq_o(ev[0]), .adc_trig_o(ev[1]), .pwm_out_pin0_o(ev[2]));

	// second unit shares bus and pins; its read data shows the unit 1 source and select
	stp_timer #(.UNIT(1)) dut1 (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat1), .wb_ack_o(),
		.comparator1_event_i(pins[0]), .comparator2_event_i(pins[1]), .ext_irq_input_i(pins[2]),
		.match_irq_o(), .adc_trig_o(), .pwm_out_pin0_o());

	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	function automatic int rnd(input int r);
		rnd = int'($unsigned($random(seed)) % r);
	endfunction

	// whether unit u captures in capture step k; step 6 runs with the count stopped
	function automatic logic cap_exp(input int u, input int k);
		cap_exp = (k < 6) && ((u == 1) ? (k % 3 == 0) : (k % 3 == ((k / 3) ? 2 : 1)));
	endfunction

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle; read data taken at the ack edge
	task automatic bus(input logic [7:0] a_i, input logic w, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a_i;
		dat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		q = rdat;
		q1 = rdat1;
		cyc <= 1'b0;
		if (t >= 50) begin
			error_cnt++;
			$display("Error at %0t: bus timeout", $time);
			stop_test;
		end
	endtask

	// cycles until an event output reaches lvl; c equals lim when it never does
	task automatic wt(input int bi, input logic lvl, input int lim);
		c = 0;
		@(posedge clk_i);
		#1;
		while (ev[bi] !== lvl && c < lim) begin
			@(posedge clk_i);
			#1;
			c++;
		end
		if (c == LIM) begin
			error_cnt++;
			$display("Error at %0t: event timeout", $time);
			stop_test;
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 21838;
		error_cnt = 0;
		n_tests = 0;
		rst_i = 1'b1;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		pins = 3'h0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, then an unmapped place
		bus(`STP_OFS_CR1, 1'b0, 32'h0);
		chk(q, {16'h0, `STP_RST_CMP});
		bus(`STP_OFS_CCR0, 1'b0, 32'h0);
		chk(q, 32'h0);
		bus(8'h3c, 1'b0, 32'h0);
		chk(q, 32'h0);
		$display("test reset done");
		// interval on each period register, then stop
		for (k = 0; k < 2; k++) begin
			n = 1 + rnd(20);
			bus(k ? `STP_OFS_CR3 : `STP_OFS_CR1, 1'b1, 32'(n));
			bus(`STP_OFS_CTRL1, 1'b1, 32'(k << `STP_PER_SEL_BIT));
			// second pass also divides the count clock by two
			bus(`STP_OFS_CTRL0, 1'b1, 32'h80 | 32'(k));
			wt(0, 1'b1, LIM);
			wt(0, 1'b1, LIM);
			chk(32'(c), 32'(((n + 1) << k) - 1));
			bus(`STP_OFS_CTRL0, 1'b1, 32'h0);
			wt(0, 1'b1, 100);
			chk(32'(c), 32'd100);
		end
		$display("test interval done");
		// conversion trigger: place, period, gate and ordering limit
		n = 3 + rnd(20);
		m = rnd(n);
		bus(`STP_OFS_CR1, 1'b1, 32'(n));
		bus(`STP_OFS_CCR0, 1'b1, 32'(m));
		bus(`STP_OFS_CTRL1, 1'b1, 32'(`STP_MODE_ADC));
		bus(`STP_OFS_CTRL2, 1'b1, 32'h2);
		bus(`STP_OFS_CTRL0, 1'b1, 32'h80);
		wt(0, 1'b1, LIM);
		wt(1, 1'b1, LIM);
		chk(32'(c), 32'(m));
		wt(1, 1'b1, LIM);
		chk(32'(c), 32'(n));
		wt(0, 1'b1, LIM);
		chk(32'(c), 32'(n - m - 1));
		bus(`STP_OFS_CTRL2, 1'b1, 32'h0);
		wt(1, 1'b1, 3 * n);
		chk(32'(c), 32'(3 * n));
		bus(`STP_OFS_CCR0, 1'b1, 32'(n));
		bus(`STP_OFS_CTRL2, 1'b1, 32'h2);
		wt(1, 1'b1, 3 * n);
		chk(32'(c), 32'(3 * n));
		$display("test trigger done");
		// capture: every source under both select values
		bus(`STP_OFS_CTRL1, 1'b1, 32'(`STP_MODE_CAPTURE));
		for (k = 0; k < 7; k++) begin
			e = cap_exp(0, k);
			bus(`STP_OFS_CTRL0, 1'b1, (k < 6) ? 32'h80 : 32'h0);
			bus(`STP_OFS_CTRL2, 1'b1, 32'(k / 3));
			bus(`STP_OFS_CTRL2, 1'b0, 32'h0);
			chk(q, 32'(k / 3));
			chk(q1, 32'((k / 3) & 2));
			bus(`STP_OFS_CCR0, 1'b1, 32'hffff);
			bus(`STP_OFS_STATUS, 1'b1, 32'h7);
			pins <= (k < 6) ? 3'h1 << (k % 3) : 3'h6;
			repeat (5) @(posedge clk_i);
			pins <= 3'h0;
			repeat (5) @(posedge clk_i);
			bus(`STP_OFS_STATUS, 1'b0, 32'h0);
			chk(q[2], e[0]);
			chk(q1[2], cap_exp(1, k));
			bus(`STP_OFS_CCR0, 1'b0, 32'h0);
			chk(e ? (q <= n) : (q === 32'hffff), 1'b1);
			chk(cap_exp(1, k) ? (q1 <= n) : (q1 === 32'hffff), 1'b1);
		end
		$display("test capture done");
		// single pwm: shape, run-time update with latest values, equal compares
		b = 4 + rnd(30);
		a = rnd(b);
		bus(`STP_OFS_CR0, 1'b1, 32'(a));
		bus(`STP_OFS_CR1, 1'b1, 32'(b));
		bus(`STP_OFS_CTRL1, 1'b1, 32'(`STP_MODE_PWM));
		bus(`STP_OFS_CTRL0, 1'b1, 32'h80);
		// start measuring from a cycle match, so a zero invert count is seen in time
		wt(0, 1'b1, LIM);
		wt(2, 1'b1, LIM);
		chk(32'(c), 32'(a));
		wt(2, 1'b0, LIM);
		chk(32'(c), 32'(b - a - 1));
		wt(2, 1'b1, LIM);
		chk(32'(c), 32'(a));
		a = rnd(b);
		n = b + 1 + rnd(10);
		bus(`STP_OFS_CR0, 1'b1, 32'(a));
		bus(`STP_OFS_CR1, 1'b1, 32'(b));
		bus(`STP_OFS_CR1, 1'b1, 32'(n));
		for (k = 0; k < 3; k++) wt(0, 1'b1, LIM);
		chk(32'(c), 32'(n));
		wt(2, 1'b1, LIM);
		wt(2, 1'b0, LIM);
		chk(32'(c), 32'(n - a - 1));
		bus(`STP_OFS_CR0, 1'b1, 32'(n));
		bus(`STP_OFS_CR1, 1'b1, 32'(n));
		for (k = 0; k < 2; k++) wt(0, 1'b1, LIM);
		wt(2, 1'b1, 3 * n);
		chk(32'(c), 32'(3 * n));
		$display("test pwm done");
		stop_test;
	end
endmodule // testbench

// file: verification/stp_timer_chk.sv
// concurrent checks on the ports of the timer channel
`timescale 1ns/100ps

module stp_timer_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        match_irq_o,
	input wire logic        adc_trig_o,
	input wire logic        pwm_out_pin0_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// a request counts only while no answer is standing
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_read;
		s_take ##0 !wb_we_i;
	endsequence

	AST_ACK_ONE: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after request");
	AST_IDLE_NO_ACK: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	AST_UNMAPPED_ZERO: assert property ((s_read ##0 wb_adr_i[7:2] > 6'h09) |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_UPPER_ZERO: assert property (s_read |=> wb_dat_o[31:16] == 16'h0)
		else $error("upper read bits not zero");
	AST_RESET_QUIET: assert property ($fell(rst_i) |-> !(match_irq_o || adc_trig_o || pwm_out_pin0_o || wb_ack_o))
		else $error("outputs active after reset");

	// ----------------------------------------
	// timer events
	// ----------------------------------------
	AST_MATCH_PULSE: assert property (match_irq_o |=> !match_irq_o)
		else $error("match pulse too long");
	AST_TRIG_PULSE: assert property (adc_trig_o |=> !adc_trig_o)
		else $error("trigger pulse too long");
	AST_TRIG_NOT_MATCH: assert property (adc_trig_o |-> !match_irq_o)
		else $error("trigger on the period match");
	AST_PWM_RISE: assert property ($rose(pwm_out_pin0_o) |-> !match_irq_o)
		else $error("pwm rise on cycle match");
	AST_PWM_LOW_AT_MATCH: assert property (match_irq_o |-> !pwm_out_pin0_o)
		else $error("pwm high at cycle match");
endmodule // stp_timer_chk

bind stp_timer stp_timer_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.match_irq_o(match_irq_o), .adc_trig_o(adc_trig_o), .pwm_out_pin0_o(pwm_out_pin0_o));
